// ---- logic/rpcr_lock_if.sv ----
`timescale 1ns/1ns
interface rpcr_lock_if;
  logic lock_sync;
  logic lock_fall;
  modport mon (output lock_sync, output lock_fall);
  modport use_side (input lock_sync, input lock_fall);
endinterface

// ---- logic/rpcr_lock_sync.sv ----
`timescale 1ns/1ns
module rpcr_lock_sync (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic pll_lock_raw,
  rpcr_lock_if.mon lk
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else if (ce) begin
      meta_reg <= pll_lock_raw; // R13
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end
  assign lk.lock_sync = sync_reg;
  assign lk.lock_fall = ce & prev_reg & ~sync_reg; // R13
endmodule // rpcr_lock_sync

// ---- logic/rpcr_pkg.sv ----
// What this block does
// R1: the two-bit loop bandwidth field is stored read-write and handed to the pll unchanged.
// R2: one invert enable per output one to four inverts that output's buffer when set.
// R3: a set spread-spectrum disable bit makes the pll ignore the fractional input and spread code.
// R4: a set integer mode bit runs the pll integer-n only, ignoring fractional and spread codes.
// R5: bits six down to two power down the buffers of outputs five down to one when set.
// R6: the two-bit fifth-output divider select means divide by 4, 6, 8 or 12.
// R7: with strap override set, input mode, reference select and table select come from the register.
// R8: a sticky bit is set when the pll loses lock, and stays set until cleared.
// R9: writing one clears the sticky unlock bit and writing zero leaves it alone.
// R10: configuration writes land in shadow storage and reach the pll on the next soft reset.
// R11: writing one to the force-latch bit copies the shadow configuration to the pll at once.
// R12: the force-latch bit clears itself once the latch is done and reads back as zero.
// R13: the lock indicator is synchronised and a falling edge of it sets the sticky unlock bit.
// R14: with lock override set, the pll is reported locked whatever the detector says.
// R15: the reference select applies only under strap override: 36, 40, 25 or 125 mhz.
// R16: the table select applies only under strap override and then the internal divider table is used.
// R17: the input mode bit applies only under strap override and reads as zero otherwise.
package rpcr_pkg;
  localparam logic [7:0] rpcr_cfg3_addr = 8'hbc;
  localparam logic [7:0] rpcr_misc_addr = 8'h90;
  localparam logic [15:0] rpcr_cfg3_reset = 16'h0178;
  localparam logic [15:0] rpcr_misc_reset = 16'h0022;
  localparam logic [15:0] rpcr_cfg3_mask = 16'hdfff;
  localparam logic [15:0] rpcr_misc_mask = 16'h9fff;
  localparam int rpcr_bw_hi = 15;
  localparam int rpcr_bw_lo = 14;
  localparam int rpcr_inv_hi = 12;
  localparam int rpcr_inv_lo = 9;
  localparam int rpcr_ssc_bit = 8;
  localparam int rpcr_intn_bit = 7;
  localparam int rpcr_pd_hi = 6;
  localparam int rpcr_pd_lo = 2;
  localparam int rpcr_div_hi = 1;
  localparam int rpcr_div_lo = 0;
  localparam int rpcr_ovr_bit = 15;
  localparam int rpcr_unlk_bit = 14;
  localparam int rpcr_force_bit = 13;
  localparam int rpcr_lock_override_bit = 10;
  localparam int rpcr_tbl_bit = 7;
  localparam int rpcr_clk_hi = 5;
  localparam int rpcr_clk_lo = 4;
  localparam int rpcr_mode_bit = 3;
  localparam logic [1:0] rpcr_resp_okay = 2'h0;
  localparam logic [1:0] rpcr_resp_slverr = 2'h2;
  localparam logic [3:0] rpcr_div4 = 4'h4;
  localparam logic [3:0] rpcr_div6 = 4'h6;
  localparam logic [3:0] rpcr_div8 = 4'h8;
  localparam logic [3:0] rpcr_div12 = 4'hc;
  typedef enum logic [1:0] {rpcr_ref_36, rpcr_ref_40, rpcr_ref_25, rpcr_ref_125} rpcr_ref_type;
endpackage

// ---- logic/rpcr_top.sv ----
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module rpcr_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic soft_reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pll_lock_raw,
  input wire logic strap_input_mode,
  input wire logic [1:0] strap_refclk_freq_sel,
  input wire logic strap_divider_table_sel,
  output logic [1:0] loop_bandwidth_sel,
  output logic [3:0] output_invert_en,
  output logic spread_spectrum_disable,
  output logic integer_mode,
  output logic frac_ssc_apply,
  output logic [4:0] out_buffer_powerdown,
  output logic [1:0] out5_divider_sel,
  output logic [3:0] out5_divide_ratio,
  output logic input_mode,
  output logic [1:0] refclk_freq_sel,
  output logic divider_table_sel,
  output logic pll_locked
);
  import rpcr_pkg::*;

  function automatic logic [15:0] rpcr_merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
    rpcr_merge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic [3:0] rpcr_ratio(input logic [1:0] sel);
    case (sel)
      2'h0: rpcr_ratio = rpcr_div4;
      2'h1: rpcr_ratio = rpcr_div6;
      2'h2: rpcr_ratio = rpcr_div8;
      default: rpcr_ratio = rpcr_div12;
    endcase
  endfunction

  rpcr_lock_if lk ();
  rpcr_lock_sync u_sync (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .pll_lock_raw(pll_lock_raw),
    .lk(lk)
  );

  // shadow copies written by software
  logic [15:0] cfg3_reg;
  logic [15:0] misc_reg;
  // values the pll actually sees
  logic [15:0] cfg3_live_reg;
  logic [15:0] misc_live_reg;
  logic unlk_reg;
  logic force_reg;
  logic srst_n_prev_reg;

  logic aw_held_reg;
  logic [7:0] aw_addr_reg;
  logic w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  wire aw_take = s_axi_awvalid & ~aw_held_reg & ~bvalid_reg;
  wire w_take = s_axi_wvalid & ~w_held_reg & ~bvalid_reg;
  wire have_aw = aw_held_reg | aw_take;
  wire have_w = w_held_reg | w_take;
  wire [7:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
  wire [3:0] wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
  wire wr_fire = ce & have_aw & have_w & ~bvalid_reg;
  wire wr_cfg3 = wr_fire & (wr_addr == rpcr_cfg3_addr);
  wire wr_misc = wr_fire & (wr_addr == rpcr_misc_addr);
  wire wr_bad = ~(wr_addr == rpcr_cfg3_addr) & ~(wr_addr == rpcr_misc_addr);
  wire [15:0] misc_wval = rpcr_merge(misc_reg, wr_data, wr_strb);
  wire unlk_clr = wr_misc & wr_strb[1] & wr_data[rpcr_unlk_bit]; // R9
  wire force_set = wr_misc & wr_strb[1] & wr_data[rpcr_force_bit]; // R11
  wire soft_rst_edge = srst_n_prev_reg & ~soft_reset_n;
  wire do_latch = soft_rst_edge | force_reg; // R10 R11

  wire rd_fire = ce & s_axi_arvalid & ~rvalid_reg;
  wire rd_cfg3 = s_axi_araddr == rpcr_cfg3_addr;
  wire rd_misc = s_axi_araddr == rpcr_misc_addr;
  wire [15:0] misc_view = (misc_reg & rpcr_misc_mask) | ({15'h0000, unlk_reg} << rpcr_unlk_bit) |
                          ({15'h0000, force_reg} << rpcr_force_bit);
  wire [15:0] rd_val = rd_cfg3 ? cfg3_reg : (rd_misc ? misc_view : 16'h0000);

  wire ovr_live = misc_live_reg[rpcr_ovr_bit];
  wire intn_live = cfg3_live_reg[rpcr_intn_bit];
  wire ssc_live = cfg3_live_reg[rpcr_ssc_bit];

  always_ff @(posedge clk) begin
    if (srst) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= rpcr_resp_okay;
    end else if (ce) begin
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_bad ? rpcr_resp_slverr : rpcr_resp_okay;
      end else begin
        if (aw_take) begin
          aw_held_reg <= 1'b1;
          aw_addr_reg <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held_reg <= 1'b1;
          w_data_reg <= s_axi_wdata;
          w_strb_reg <= s_axi_wstrb;
        end
        if (bvalid_reg & s_axi_bready) begin
          bvalid_reg <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= rpcr_resp_okay;
    end else if (ce) begin
      if (rd_fire) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= {16'h0000, rd_val};
        rresp_reg <= (rd_cfg3 | rd_misc) ? rpcr_resp_okay : rpcr_resp_slverr;
      end else if (rvalid_reg & s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg3_reg <= rpcr_cfg3_reset;
      misc_reg <= rpcr_misc_reset & rpcr_misc_mask;
    end else if (ce) begin
      if (wr_cfg3) begin
        cfg3_reg <= rpcr_merge(cfg3_reg, wr_data, wr_strb) & rpcr_cfg3_mask; // R1 R2 R5 R6 R10
      end
      if (wr_misc) begin
        misc_reg <= misc_wval & rpcr_misc_mask; // R10
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      unlk_reg <= 1'b0;
      force_reg <= 1'b0;
      srst_n_prev_reg <= 1'b1;
    end else if (ce) begin
      srst_n_prev_reg <= soft_reset_n;
      if (lk.lock_fall) begin
        unlk_reg <= 1'b1; // R8 R13
      end else if (unlk_clr) begin
        unlk_reg <= 1'b0; // R9
      end
      if (force_reg) begin
        force_reg <= 1'b0; // R12
      end else if (force_set) begin
        force_reg <= 1'b1; // R11
      end
    end
  end

  // the pll keeps the old setting until a latch moves the shadow across
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg3_live_reg <= rpcr_cfg3_reset;
      misc_live_reg <= rpcr_misc_reset & rpcr_misc_mask;
    end else if (ce) begin
      if (do_latch) begin
        cfg3_live_reg <= cfg3_reg; // R10 R11
        misc_live_reg <= misc_reg;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      loop_bandwidth_sel <= 2'h0;
      output_invert_en <= 4'h0;
      spread_spectrum_disable <= 1'b0;
      integer_mode <= 1'b0;
      frac_ssc_apply <= 1'b0;
      out_buffer_powerdown <= 5'h00;
      out5_divider_sel <= 2'h0;
      out5_divide_ratio <= rpcr_div4;
      input_mode <= 1'b0;
      refclk_freq_sel <= rpcr_ref_36;
      divider_table_sel <= 1'b0;
      pll_locked <= 1'b0;
    end else if (ce) begin
      loop_bandwidth_sel <= cfg3_live_reg[rpcr_bw_hi:rpcr_bw_lo]; // R1
      output_invert_en <= cfg3_live_reg[rpcr_inv_hi:rpcr_inv_lo]; // R2
      spread_spectrum_disable <= ssc_live; // R3
      integer_mode <= intn_live; // R4
      frac_ssc_apply <= ~ssc_live & ~intn_live; // R3 R4
      out_buffer_powerdown <= cfg3_live_reg[rpcr_pd_hi:rpcr_pd_lo]; // R5
      out5_divider_sel <= cfg3_live_reg[rpcr_div_hi:rpcr_div_lo];
      out5_divide_ratio <= rpcr_ratio(cfg3_live_reg[rpcr_div_hi:rpcr_div_lo]); // R6
      input_mode <= ovr_live & misc_live_reg[rpcr_mode_bit]; // R7 R17
      refclk_freq_sel <= ovr_live ? misc_live_reg[rpcr_clk_hi:rpcr_clk_lo] : strap_refclk_freq_sel; // R7 R15
      divider_table_sel <= ovr_live ? misc_live_reg[rpcr_tbl_bit] : strap_divider_table_sel; // R7 R16
      pll_locked <= misc_live_reg[rpcr_lock_override_bit] | lk.lock_sync; // R14
    end
  end

  // ready is offered only while a slot is free and no response is pending
  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
endmodule // rpcr_top

// ---- testbench/rpcr_pll_model.sv ----
`timescale 1ns/1ns
module rpcr_pll_model (
  input wire logic clk,
  input wire logic drop,
  output logic lock,
  output logic strap_mode,
  output logic [1:0] strap_clk,
  output logic strap_tbl
);
  // clock and table straps chosen to differ from the register values used under override; the mode strap matches them
  assign strap_mode = 1'b1;
  assign strap_clk = 2'h2;
  assign strap_tbl = 1'b1;
  always @(posedge clk) begin
    lock <= !drop;
  end
endmodule // rpcr_pll_model

// ---- testbench/rpcr_top_asserts.sv ----
`timescale 1ns/1ns
module rpcr_top_asserts (
  input wire logic clk,
  input wire logic srst,
  input wire logic soft_reset_n,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic pll_lock_raw,
  input wire logic [1:0] loop_bandwidth_sel,
  input wire logic spread_spectrum_disable,
  input wire logic integer_mode,
  input wire logic frac_ssc_apply,
  input wire logic [1:0] out5_divider_sel,
  input wire logic [3:0] out5_divide_ratio,
  input wire logic pll_locked
);
  import rpcr_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  frac_apply_a: assert property (!$past(srst) |-> frac_ssc_apply == (!spread_spectrum_disable && !integer_mode))
    else $error("fractional apply disagrees with mode bits");
  div_ratio_a: assert property (out5_divide_ratio == (out5_divider_sel == 2'h0 ? rpcr_div4 :
    out5_divider_sel == 2'h1 ? rpcr_div6 : out5_divider_sel == 2'h2 ? rpcr_div8 : rpcr_div12))
    else $error("fifth output ratio wrong");
  wr_resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rd_data_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr != rpcr_cfg3_addr &&
    s_axi_araddr != rpcr_misc_addr |=> s_axi_rresp == rpcr_resp_slverr && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  lock_follow_a: assert property (pll_lock_raw [*5] |=> pll_locked)
    else $error("lock not reported");
  shadow_only_a: assert property (!$past(srst) && !$past(srst, 2) && $changed(loop_bandwidth_sel) |->
    !$past(soft_reset_n) || !$past(soft_reset_n, 2) || !$past(soft_reset_n, 3) ||
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3))
    else $error("live config changed without latch");
endmodule // rpcr_top_asserts

// ---- testbench/testbench.sv ----
`timescale 1ns/1ns
module testbench;
  import rpcr_pkg::*;
  logic clk = 1'b0, srst = 1'b1, ce = 1'b1, soft_reset_n = 1'b1, drop = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'hf, inv, ratio;
  logic [1:0] bresp, rresp, r, sclk, bw, d5sel, rsel;
  logic awready, wready, bvalid, arready, rvalid, lock, smode, stbl, ssd, intn, frac, imode, tbl, locked;
  logic [4:0] pd;
  logic [3:0] rt [4] = '{rpcr_div4, rpcr_div6, rpcr_div8, rpcr_div12};
  int bad_count = 0, compares = 0;
  always #5 clk = ~clk;
  rpcr_pll_model pll (.clk(clk), .drop(drop), .lock(lock), .strap_mode(smode), .strap_clk(sclk), .strap_tbl(stbl));
  rpcr_top DUT (.clk(clk), .srst(srst), .ce(ce), .soft_reset_n(soft_reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pll_lock_raw(lock), .strap_input_mode(smode), .strap_refclk_freq_sel(sclk), .strap_divider_table_sel(stbl),
    .loop_bandwidth_sel(bw), .output_invert_en(inv), .spread_spectrum_disable(ssd), .integer_mode(intn),
    .frac_ssc_apply(frac), .out_buffer_powerdown(pd), .out5_divider_sel(d5sel), .out5_divide_ratio(ratio),
    .input_mode(imode), .refclk_freq_sel(rsel), .divider_table_sel(tbl), .pll_locked(locked));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // handshakes are judged on values settled mid-cycle, which stand at the next rising edge
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic sa, sw, sb;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      sa = awvalid & awready;
      sw = wvalid & wready;
      sb = bvalid;
      r = bresp;
      @(posedge clk);
      if (sa) awvalid <= 1'b0;
      if (sw) wvalid <= 1'b0;
    end while (!sb);
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    logic sa, sr;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      sa = arvalid & arready;
      sr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (sa) arvalid <= 1'b0;
    end while (!sr);
    rready <= 1'b0;
  endtask
  // force bit added so the shadow copy goes live at once
  task lat(input logic [15:0] m);
    wr(rpcr_misc_addr, {16'h0, m | 16'h2000});
    repeat (4) @(posedge clk);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    rd(rpcr_cfg3_addr);
    chk(d, 32'h0178);
    rd(rpcr_misc_addr);
    chk(d, 32'h0022);
    chk({ssd, pd, d5sel, ratio}, {1'b1, 5'h1e, 2'h0, rpcr_div4});
    wr(rpcr_cfg3_addr, 32'h4e07);
    chk(r, rpcr_resp_okay);
    repeat (4) @(posedge clk);
    chk({bw, inv}, 6'h0);
    soft_reset_n <= 1'b0;
    @(posedge clk);
    soft_reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({bw, inv, ssd, intn, frac, pd, d5sel}, {2'h1, 4'h7, 3'b001, 5'h01, 2'h3});
    for (int i = 0; i < 4; i++) begin
      wr(rpcr_cfg3_addr, 32'h0080 | i);
      lat(16'h0);
      chk({intn, frac, ratio}, {2'b10, rt[i]});
      rd(rpcr_misc_addr);
      chk(d[13], 1'b0);
    end
    chk({imode, rsel, tbl}, {1'b0, 2'h2, 1'b1});
    lat(16'h8038);
    chk({imode, rsel, tbl}, {1'b1, 2'h3, 1'b0});
    drop <= 1'b1;
    repeat (6) @(posedge clk);
    chk(locked, 1'b0);
    lat(16'h0400);
    chk(locked, 1'b1);
    drop <= 1'b0;
    repeat (6) @(posedge clk);
    rd(rpcr_misc_addr);
    chk(d[14], 1'b1);
    wr(rpcr_misc_addr, 32'h0);
    rd(rpcr_misc_addr);
    chk(d[14], 1'b1);
    wr(rpcr_misc_addr, 32'h4000);
    rd(rpcr_misc_addr);
    chk(d[14], 1'b0);
    wr(8'h44, 32'h1);
    chk(r, rpcr_resp_slverr);
    rd(8'h44);
    chk({r, d[29:0]}, {rpcr_resp_slverr, 30'h0});
    stop_test;
  end
  initial begin
    #100000;
    bad_count++;
    stop_test;
  end
endmodule // testbench
bind rpcr_top rpcr_top_asserts chk_i (.clk(clk), .srst(srst), .soft_reset_n(soft_reset_n),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .pll_lock_raw(pll_lock_raw),
  .loop_bandwidth_sel(loop_bandwidth_sel), .spread_spectrum_disable(spread_spectrum_disable),
  .integer_mode(integer_mode), .frac_ssc_apply(frac_ssc_apply), .out5_divider_sel(out5_divider_sel),
  .out5_divide_ratio(out5_divide_ratio), .pll_locked(pll_locked));
